// ---- alcm_map.svh ----
// constants for the adaptive line comb mixer
// Function
// RL1 - The comb adds or subtracts the high band of three adjacent lines so opposite-phase chroma cancels and averaged high-band luma remains.
// RL2 - Three comb-failure error signals are formed and fed into a user-loaded lookup table.
// RL3 - Every line tap is also bandsplit, low band taken as luma and high band as chroma giving magnitude and phase.
// RL4 - Luma, chroma magnitude and chroma phase are compared between taps zero/one and one/two to give differences.
// RL5 - The differences index the lookup table whose output is the mix coefficient.
// RL6 - The coefficient weights comb and bandsplit results complementarily so the weights sum to the whole.
// RL7 - Output chroma is bandsplit chroma minus the coefficient-scaled combed high-band luma.
// RL8 - Output luma is bandsplit low band plus the coefficient-scaled combed high-band luma.
// RL9 - The comb stage can be set to any one of sixteen comb architectures.
// RL10 - The decoder select picks adaptive comb (00), simple bandsplit (01), notched luma with bandsplit chroma (11); 10 is reserved.
// RL11 - Line stores delay video by one and two lines so all three taps align at the same pixel.
// RL12 - Lookup table entries are writable and a new entry applies from the next pixel after the write.
`ifndef ALCM_MAP_SVH
`define ALCM_MAP_SVH
`define ALCM_VW          10
`define ALCM_PTR_W       10
`define ALCM_PTR_LAST    10'h3ff
`define ALCM_PTR_ZERO    10'h000
`define ALCM_LUT_AW      8
`define ALCM_LUT_DEPTH   256
`define ALCM_K_W         5
`define ALCM_K_FULL      5'h10
`define ALCM_K_ZERO      5'h00
`define ALCM_K_SHIFT     4
`define ALCM_LUMA_MAX    17'sh003ff
`define ALCM_CHROMA_MAX  17'sh001ff
`define ALCM_CHROMA_MIN  -17'sh00200
`define ALCM_BUF_FULL    2'h2
`define ALCM_SEL_LO      2
`define ALCM_SEL_INV     2
`define ALCM_SEL_KFULL   3
`endif

// ---- alcm_mixer.sv ----
// adaptive three-line comb separator with lookup-table mix and output skid buffer
`timescale 1ns/1ps
`include "alcm_map.svh"

module alcm_mixer (
   // clock, reset, enable
   input  wire logic                 clock_i,
   input  wire logic                 reset_n_i,
   input  wire logic                 ce_i,
   // configuration
   input  wire logic [1:0]           dec_sel_i,
   input  wire logic [3:0]           comb_mode_i,
   input  wire alcm_pkg::alcm_lut_wr_t lut_wr_i,
   // video in
   input  wire logic                 in_valid_i,
   input  wire alcm_pkg::alcm_pix_t  in_pix_i,
   output      logic                 in_ready_o,
   // components out
   output      logic                 out_valid_o,
   output      alcm_pkg::alcm_out_t  out_data_o,
   input  wire logic                 out_ready_i
);
   import alcm_pkg::*;

   // line stores and table; no reset on arrays, so the table must be loaded before use
   logic [`ALCM_VW-1:0]  store_a [`ALCM_LUT_DEPTH*4];
   logic [`ALCM_VW-1:0]  store_b [`ALCM_LUT_DEPTH*4];
   logic [`ALCM_K_W-1:0] lut     [`ALCM_LUT_DEPTH];

   logic                  accept;
   logic [`ALCM_PTR_W-1:0] ptr, next_ptr, wr_addr;
   logic [`ALCM_VW-1:0]   hz [3][3];
   logic [`ALCM_VW-1:0]   next_hz [3][3];
   logic                  s1_valid, next_s1_valid;

   assign accept = ce_i & in_valid_i & in_ready_o;

   // ---------------- stage 1: line stores and horizontal taps ----------------
   always_comb begin
      wr_addr = in_pix_i.line_start ? `ALCM_PTR_ZERO : ptr;
      next_ptr = ptr;
      next_hz = hz;
      next_s1_valid = s1_valid;
      if (accept) begin
         next_ptr = (wr_addr == `ALCM_PTR_LAST) ? `ALCM_PTR_ZERO : wr_addr + 1'b1;
         for (int t = 0; t < 3; t++) begin
            next_hz[t][2] = hz[t][1];
            next_hz[t][1] = hz[t][0];
         end
         // taps aligned on the same horizontal position [RL11]
         next_hz[0][0] = in_pix_i.video;
         next_hz[1][0] = store_a[wr_addr];
         next_hz[2][0] = store_b[wr_addr];
         next_s1_valid = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr <= `ALCM_PTR_ZERO;
         s1_valid <= 1'b0;
         for (int t = 0; t < 3; t++) begin
            for (int h = 0; h < 3; h++) begin
               hz[t][h] <= '0;
            end
         end
      end else if (ce_i) begin
         ptr <= next_ptr;
         s1_valid <= next_s1_valid;
         hz <= next_hz;
      end
   end

   // one- and two-line delays [RL11]
   always_ff @(posedge clock_i) begin
      if (accept) begin
         store_a[wr_addr] <= in_pix_i.video;
         store_b[wr_addr] <= store_a[wr_addr];
      end
   end

   // table writes land before the next pixel reads it [RL12]
   always_ff @(posedge clock_i) begin
      if (ce_i && lut_wr_i.wr) begin
         lut[lut_wr_i.addr] <= lut_wr_i.k;
      end
   end

   // ---------------- stage 2: bandsplit, differences, comb, table ----------------
   logic [`ALCM_VW-1:0]   low [3];
   logic signed [10:0]    hf  [3];
   logic [`ALCM_VW-1:0]   mag [3];
   logic [1:0]            phs [3];
   logic [`ALCM_VW-1:0]   notch1;
   logic [`ALCM_VW-1:0]   ld_up, ld_lo, md_up, md_lo, ld_max, md_max;
   logic [1:0]            ph_diff;
   logic [`ALCM_LUT_AW-1:0] lut_idx;
   logic signed [12:0]    comb_sum;
   logic signed [10:0]    comb_hf;
   logic signed [10:0]    outer;
   logic [`ALCM_K_W-1:0]  k_raw, k_sel;
   alcm_dec_t             dec;

   function automatic logic [9:0] absdiff(input logic [9:0] a, input logic [9:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction : absdiff

   always_comb begin
      logic [11:0] sum3;
      logic [10:0] sum2;
      sum3 = '0;
      sum2 = '0;
      for (int t = 0; t < 3; t++) begin
         // low band is luma, high band is chroma [RL3]
         sum3 = {2'h0, hz[t][0]} + {1'b0, hz[t][1], 1'b0} + {2'h0, hz[t][2]};
         low[t] = sum3[11:2];
         hf[t] = $signed({1'b0, hz[t][1]}) - $signed({1'b0, low[t]});
         mag[t] = hf[t][10] ? 10'(-hf[t]) : hf[t][9:0];
         phs[t] = {hf[t][10], hz[t][0] < hz[t][2]};
      end
      sum2 = {1'b0, hz[1][0]} + {1'b0, hz[1][2]};
      notch1 = sum2[10:1];
      // three comb-failure measures per tap pair [RL2] [RL4]
      ld_up = absdiff(low[0], low[1]);
      ld_lo = absdiff(low[1], low[2]);
      md_up = absdiff(mag[0], mag[1]);
      md_lo = absdiff(mag[1], mag[2]);
      ld_max = (ld_up > ld_lo) ? ld_up : ld_lo;
      md_max = (md_up > md_lo) ? md_up : md_lo;
      ph_diff = (phs[0] ^ phs[1]) | (phs[1] ^ phs[2]);
      lut_idx = {ld_max[9:7], md_max[9:7], ph_diff};
   end

   // comb architecture: bits 1:0 tap set, bit 2 outer-tap sign, bit 3 forced full comb [RL9]
   always_comb begin
      comb_sum = '0;
      outer = comb_mode_i[`ALCM_SEL_INV] ? -hf[0] : hf[0];
      unique case (comb_mode_i[1:0])
         2'h0: comb_sum = 13'(outer) + 13'(hf[1]);
         2'h1: comb_sum = 13'(hf[1]) + 13'(comb_mode_i[`ALCM_SEL_INV] ? -hf[2] : hf[2]);
         2'h2: comb_sum = (13'(outer) + (13'(hf[1]) <<< 1)
                          + 13'(comb_mode_i[`ALCM_SEL_INV] ? -hf[2] : hf[2])) >>> 1;
         2'h3: comb_sum = (ld_up <= ld_lo) ? 13'(outer) + 13'(hf[1])
                          : 13'(hf[1]) + 13'(comb_mode_i[`ALCM_SEL_INV] ? -hf[2] : hf[2]);
      endcase
      // chroma of opposite phase cancels, high-band luma averages [RL1]
      comb_hf = 11'(comb_sum >>> 1);
   end

   always_comb begin
      dec = alcm_dec_t'(dec_sel_i);
      // table output is the mix coefficient [RL5]
      k_raw = lut[lut_idx];
      if (comb_mode_i[`ALCM_SEL_KFULL]) begin
         k_raw = `ALCM_K_FULL;
      end
      // cap keeps comb and bandsplit weights summing to one [RL6]
      if (k_raw > `ALCM_K_FULL) begin
         k_raw = `ALCM_K_FULL;
      end
      // reserved select falls back to plain bandsplit [RL10]
      unique case (dec)
         ALCM_DEC_ADAPTIVE:  k_sel = k_raw;
         ALCM_DEC_BANDSPLIT: k_sel = `ALCM_K_ZERO;
         ALCM_DEC_RESERVED:  k_sel = `ALCM_K_ZERO;
         ALCM_DEC_NOTCH:     k_sel = `ALCM_K_ZERO;
      endcase
   end

   logic                  s2_valid, next_s2_valid;
   logic [`ALCM_K_W-1:0]  s2_k, next_s2_k;
   logic signed [10:0]    s2_comb, next_s2_comb, s2_hf, next_s2_hf;
   logic [`ALCM_VW-1:0]   s2_low, next_s2_low;
   logic                  s2_notch, next_s2_notch;

   always_comb begin
      next_s2_valid = s2_valid;
      next_s2_k = s2_k;
      next_s2_comb = s2_comb;
      next_s2_hf = s2_hf;
      next_s2_low = s2_low;
      next_s2_notch = s2_notch;
      if (accept) begin
         next_s2_valid = s1_valid;
         next_s2_k = k_sel;
         next_s2_comb = comb_hf;
         next_s2_hf = hf[1];
         // notched luma mode swaps the low band for the notch [RL10]
         next_s2_low = (dec == ALCM_DEC_NOTCH) ? notch1 : low[1];
         next_s2_notch = (dec == ALCM_DEC_NOTCH);
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s2_valid <= 1'b0;
         s2_k <= `ALCM_K_ZERO;
         s2_comb <= '0;
         s2_hf <= '0;
         s2_low <= '0;
         s2_notch <= 1'b0;
      end else if (ce_i) begin
         s2_valid <= next_s2_valid;
         s2_k <= next_s2_k;
         s2_comb <= next_s2_comb;
         s2_hf <= next_s2_hf;
         s2_low <= next_s2_low;
         s2_notch <= next_s2_notch;
      end
   end

   // ---------------- stage 3: blend, clamp, two-entry buffer ----------------
   logic signed [16:0] scaled, y_raw, c_raw;
   alcm_out_t          blended;
   logic               push, pop;
   alcm_out_t          buf0, buf1, next_buf0, next_buf1;
   logic [1:0]         cnt, next_cnt;
   logic               next_in_ready, next_out_valid;

   always_comb begin
      scaled = (17'(s2_comb) * $signed({12'h000, s2_k})) >>> `ALCM_K_SHIFT;
      // chroma loses what the comb moved into luma [RL7]
      c_raw = 17'(s2_hf) - scaled;
      // luma gains the combed high band [RL8]
      y_raw = $signed({7'h00, s2_low}) + scaled;
      if (y_raw < 0) begin
         blended.luma = '0;
      end else if (y_raw > `ALCM_LUMA_MAX) begin
         blended.luma = 10'h3ff;
      end else begin
         blended.luma = y_raw[9:0];
      end
      if (c_raw > `ALCM_CHROMA_MAX) begin
         blended.chroma = 10'sh1ff;
      end else if (c_raw < `ALCM_CHROMA_MIN) begin
         blended.chroma = -10'sh200;
      end else begin
         blended.chroma = c_raw[9:0];
      end
   end

   // pipeline moves only on input accepts, so a push never meets a full buffer
   always_comb begin
      push = accept & s2_valid;
      pop = ce_i & out_valid_o & out_ready_i;
      next_buf0 = buf0;
      next_buf1 = buf1;
      next_cnt = cnt;
      if (pop) begin
         next_buf0 = buf1;
         next_cnt = next_cnt - 1'b1;
      end
      if (push) begin
         if (next_cnt == 2'h0) begin
            next_buf0 = blended;
         end else begin
            next_buf1 = blended;
         end
         next_cnt = next_cnt + 1'b1;
      end
      next_in_ready = (next_cnt != `ALCM_BUF_FULL);
      next_out_valid = (next_cnt != 2'h0);
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         buf0 <= '0;
         buf1 <= '0;
         cnt <= 2'h0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else if (ce_i) begin
         buf0 <= next_buf0;
         buf1 <= next_buf1;
         cnt <= next_cnt;
         in_ready_o <= next_in_ready;
         out_valid_o <= next_out_valid;
      end
   end

   assign out_data_o = buf0;

endmodule : alcm_mixer

// ---- alcm_mixer_checker.sv ----
// port assertions for the adaptive line comb mixer
`timescale 1ns/1ps
module alcm_mixer_checker (
   // clock and control
   input wire logic                clock_i,
   input wire logic                reset_n_i,
   input wire logic                ce_i,
   // handshakes
   input wire logic                in_valid_i,
   input wire logic                in_ready_o,
   input wire logic                out_valid_o,
   input wire alcm_pkg::alcm_out_t out_data_o,
   input wire logic                out_ready_i
);
   import alcm_pkg::*;
   logic acc;
   logic pop;
   assign acc = ce_i && in_valid_i && in_ready_o;
   assign pop = ce_i && out_valid_o && out_ready_i;
   a_reset_quiet: assert property (@(posedge clock_i)
      !reset_n_i |-> !in_ready_o && !out_valid_o && out_data_o == '0) else $error("busy in reset");
   a_ready_wake: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !$past(reset_n_i) && ce_i |=> in_ready_o) else $error("ready late after reset");
   a_head_holds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      out_valid_o && !pop |=> out_valid_o && $stable(out_data_o)) else $error("head lost");
   a_full_stays: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !in_ready_o && !pop && $past(reset_n_i) |=> !in_ready_o) else $error("ready without pop");
   a_pop_frees: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !in_ready_o && pop |=> in_ready_o) else $error("pop left buffer full");
   a_valid_cause: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(out_valid_o) |-> $past(acc) || $past(acc, 2)) else $error("valid without input");
   a_ce_freeze: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !ce_i |=> $stable(out_valid_o) && $stable(in_ready_o) && $stable(out_data_o))
      else $error("state moved with enable low");
   a_idle_quiet: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !acc ##1 (!acc && !out_valid_o) |=> !out_valid_o) else $error("valid from nothing");
endmodule : alcm_mixer_checker

bind alcm_mixer alcm_mixer_checker i_alcm_mixer_checker (.clock_i(clock_i),
   .reset_n_i(reset_n_i), .ce_i(ce_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
   .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));

// ---- alcm_mixer_tb.sv ----
// bench for the adaptive line comb mixer: table, mode and select runs
`timescale 1ns/1ps
module alcm_mixer_tb;
   import alcm_pkg::*;
   logic         clock_i, reset_n_i, ce_i, in_valid_i, out_ready_i, in_ready_o;
   logic         out_valid_o, got, stall;
   logic [1:0]   dec_sel_i;
   logic [3:0]   comb_mode_i;
   alcm_lut_wr_t lut_wr_i;
   alcm_pix_t    in_pix_i;
   alcm_out_t    out_data_o, word;
   int           n_fail = 0, cmp_count = 0, n_in = 0, n_out = 0, first = 0, kk = 0;

   alcm_mixer i_alcm_mixer (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
      .dec_sel_i(dec_sel_i), .comb_mode_i(comb_mode_i), .lut_wr_i(lut_wr_i),
      .in_valid_i(in_valid_i), .in_pix_i(in_pix_i), .in_ready_o(in_ready_o),
      .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));
   alcm_sink i_alcm_sink (.clock_i(clock_i), .ce_i(ce_i), .stall_i(stall),
      .valid_i(out_valid_o), .data_i(out_data_o), .ready_o(out_ready_i), .got_o(got),
      .word_o(word));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task summarize;
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize

   task chk(input alcm_out_t g, input alcm_out_t e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // neighbours alternate about mid grey, so low is 0x200 and hf is +-64
   function automatic alcm_out_t expect_of(int j);
      int hf, k, cb;
      hf = (j % 2) ? 64 : -64;
      k = comb_mode_i[3] ? 16 : (kk > 16 ? 16 : kk);
      if (dec_sel_i != 2'h0) k = 0;
      cb = comb_mode_i[2] ? 0 : hf * k / 16;
      expect_of.luma = 10'((dec_sel_i == 2'h3) ? 512 - hf : 512 + cb);
      expect_of.chroma = 10'(hf - cb);
   endfunction : expect_of

   // output j is centred on input j-1; early words of a run use stale taps
   always @(posedge clock_i) begin
      if (got === 1'b1) begin
         if (n_out >= first) chk(word, expect_of(n_out));
         n_out++;
      end
   end

   task lut(input logic [4:0] k);
      kk = k;
      for (int a = 0; a < 256; a++) begin
         lut_wr_i = '{1'b1, 8'(a), k};
         @(posedge clock_i);
         #1;
      end
      lut_wr_i.wr = 1'b0;
   endtask : lut

   task send(input int i);
      int b;
      b = 0;
      if (stall && i % 5 == 2) begin
         ce_i = 1'b0;
         @(posedge clock_i);
         #1;
         ce_i = 1'b1;
      end
      in_valid_i = 1'b1;
      in_pix_i = '{i % 8 == 0, n_in[0] ? 10'h1c0 : 10'h240};
      while (in_ready_o !== 1'b1 && b < 100) begin
         @(posedge clock_i);
         #1;
         b++;
      end
      if (b == 100) begin
         n_fail++;
         summarize();
      end
      @(posedge clock_i);
      #1;
      n_in++;
   endtask : send

   // five lines of eight pixels, identical from line to line
   task run(input logic [1:0] s, input logic [3:0] m, input logic st);
      int b;
      b = 0;
      dec_sel_i = s;
      comb_mode_i = m;
      stall = st;
      // two lines plus two pixels before taps one/two hold only written store words
      first = n_in + 18;
      for (int i = 0; i < 40; i++) send(i);
      // drop valid first so the drain wait does not feed uncounted pixels
      in_valid_i = 1'b0;
      while (n_out < n_in - 2 && b < 200) begin
         @(posedge clock_i);
         #1;
         b++;
      end
      if (b == 200) begin
         n_fail++;
         summarize();
      end
      @(posedge clock_i);
      #1;
   endtask : run

   task sc_table;
      lut(5'h00);
      run(2'h0, 4'h0, 1'b0);
      lut(5'h08);
      run(2'h0, 4'h0, 1'b1);
   endtask : sc_table

   task sc_modes;
      lut(5'h18);
      for (int m = 0; m < 16; m++) run(2'h0, 4'(m), m[0]);
      lut(5'h00);
      run(2'h0, 4'hb, 1'b1);
   endtask : sc_modes

   task sc_select;
      lut(5'h08);
      for (int s = 1; s < 4; s++) run(2'(s), 4'h0, 1'b0);
   endtask : sc_select

   initial begin
      reset_n_i = 1'b0;
      ce_i = 1'b1;
      in_valid_i = 1'b0;
      stall = 1'b0;
      dec_sel_i = 2'h0;
      comb_mode_i = 4'h0;
      lut_wr_i = '0;
      in_pix_i = '0;
      repeat (4) @(posedge clock_i);
      #1;
      reset_n_i = 1'b1;
      sc_table();
      sc_modes();
      sc_select();
      summarize();
   end
endmodule : alcm_mixer_tb

// ---- alcm_pkg.sv ----
// types shared by the adaptive line comb mixer
package alcm_pkg;
   typedef struct packed {
      logic       line_start;
      logic [9:0] video;
   } alcm_pix_t;

   typedef struct packed {
      logic        [9:0] luma;
      logic signed [9:0] chroma;
   } alcm_out_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [4:0] k;
   } alcm_lut_wr_t;

   typedef enum logic [1:0] {
      ALCM_DEC_ADAPTIVE = 2'h0,
      ALCM_DEC_BANDSPLIT = 2'h1,
      ALCM_DEC_RESERVED = 2'h2,
      ALCM_DEC_NOTCH = 2'h3
   } alcm_dec_t;
endpackage : alcm_pkg

// ---- alcm_sink.sv ----
// downstream sink model: takes output words, stalling when asked
`timescale 1ns/1ps
module alcm_sink (
   // clock and control
   input  wire logic                clock_i,
   input  wire logic                ce_i,
   input  wire logic                stall_i,
   // block output side
   input  wire logic                valid_i,
   input  wire alcm_pkg::alcm_out_t data_i,
   output      logic                ready_o,
   // word handed to the bench
   output      logic                got_o,
   output      alcm_pkg::alcm_out_t word_o
);
   import alcm_pkg::*;
   int n = 0;
   initial ready_o = 1'b1;
   // a stall opens one cycle in four so the skid buffer fills
   always @(posedge clock_i) begin
      got_o <= ce_i && valid_i && ready_o;
      word_o <= data_i;
      n <= n + 1;
      ready_o <= #1 !stall_i || n % 4 == 3;
   end
endmodule : alcm_sink
